// File: core/shbp_pkg.sv
package shbp_pkg;
    // Host bus geometry
    localparam int          SHBP_BUS_W        = 8;
    localparam int          SHBP_SEL_W        = 2;
    // Bus style selection on the style pin
    localparam logic        SHBP_STYLE_DS_RW  = 1'h1;
    localparam logic        SHBP_STYLE_RD_WR  = 1'h0;
    // Bus mode selection on the mode pin
    localparam logic        SHBP_MODE_MUX     = 1'h1;
    localparam logic        SHBP_MODE_DEMUX   = 1'h0;
    // Direction line level for a read in the strobe-plus-direction style
    localparam logic        SHBP_DIR_READ     = 1'h1;
    // Reset values
    localparam logic [7:0]  SHBP_ADDR_RST     = 8'h00;
    localparam logic [7:0]  SHBP_DATA_RST     = 8'h00;
    // Frame timing: one PCM frame and its length in clock cycles
    localparam int          SHBP_CLK_PERIOD_PS = 5000;
    localparam int          SHBP_FRAME_TIME_NS = 125000;
    localparam int          SHBP_FRAME_CYCLES  =
        (SHBP_FRAME_TIME_NS * 1000) / SHBP_CLK_PERIOD_PS;
    localparam int          SHBP_FCNT_W        = 16;
    localparam logic [15:0] SHBP_FCNT_RST      = 16'h0000;
endpackage

// File: core/shbp_frame_if.sv
`timescale 1ns/1ps
interface shbp_frame_if;
    import shbp_pkg::*;
    logic                   sync;
    logic                   clear;
    logic                   start;
    logic [SHBP_FCNT_W-1:0] count;
    modport timer (input sync, input clear, output start, output count);
    modport user  (output sync, output clear, input start, input count);
endinterface

// File: core/shbp_frame_timer.sv
`timescale 1ns/1ps
module shbp_frame_timer
    import shbp_pkg::*;
#(
    parameter int FRAME_CYCLES = SHBP_FRAME_CYCLES
)(
    // Clock and reset
    input  wire logic     clk_in,
    input  wire logic     reset_in,
    // Frame carrier
    shbp_frame_if.timer   frm
);
    typedef struct packed {
        logic                   start;
        logic [SHBP_FCNT_W-1:0] count;
    } shbp_tmr_t;

    localparam logic [SHBP_FCNT_W-1:0] LAST =
        SHBP_FCNT_W'(FRAME_CYCLES - 1);

    shbp_tmr_t s_q;
    shbp_tmr_t s_d;

    // Clear holds the count at zero; sync pulse restarts the frame; otherwise free-run and wrap
    always_comb
    begin
        s_d = s_q;
        s_d.start = 1'b0;
        if (frm.clear)
        begin
            s_d.count = SHBP_FCNT_RST;
        end
        else if (frm.sync)
        begin
            s_d.count = SHBP_FCNT_RST;
            s_d.start = 1'b1;
        end
        else if (s_q.count == LAST)
        begin
            s_d.count = SHBP_FCNT_RST;
            s_d.start = 1'b1;
        end
        else
        begin
            s_d.count = s_q.count + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign frm.start = s_q.start;
    assign frm.count = s_q.count;

    property p_sync_align;
        @(posedge clk_in) disable iff (reset_in)
        (frm.sync && !frm.clear) |=> (frm.count == SHBP_FCNT_RST) && frm.start;
    endproperty
    a_sync_align: assert property (p_sync_align)
        else $error("frame timing not aligned to sync pulse");
endmodule

// File: core/shbp_host_port.sv
// What this block does
// - 8-bit host port in strobe-direction or split read/write style.
// - An access counts only while device select is held low.
// - Reset input high holds the device in its reset state.
// - Strobe style: direction high means read, low means write.
// - Strobe style: rising data strobe ends a valid read or write.
// - Separate-strobe style: write strobe asserted means a write access.
// - Separate-strobe style: read strobe asserted means a read access.
// - Register-select pins pick the register, only in demultiplexed mode.
// - Frame timing aligns to the external sync pulse.
// - Multiplexed mode: bus lines carry address and data.
// - Demultiplexed mode: bus lines carry data only.
`timescale 1ns/1ps
module shbp_host_port
    import shbp_pkg::*;
#(
    parameter int FRAME_CYCLES = SHBP_FRAME_CYCLES
)(
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    // Configuration straps
    input  wire logic                   bus_style_in,
    input  wire logic                   mux_mode_in,
    // Host bus pins
    input  wire logic                   device_clear_in,
    input  wire logic                   chip_sel_n_in,
    input  wire logic                   dir_wr_n_in,
    input  wire logic                   data_strobe_rd_n_in,
    input  wire logic                   reg_select_lsb_in,
    input  wire logic                   reg_select_msb_in,
    input  wire logic [SHBP_BUS_W-1:0]  bus_data_in,
    output logic      [SHBP_BUS_W-1:0]  bus_data_out,
    output logic                        bus_oe_out,
    input  wire logic                   frame_sync_pulse_in,
    // Register side
    output logic      [SHBP_BUS_W-1:0]  reg_addr_out,
    output logic      [SHBP_BUS_W-1:0]  reg_wdata_out,
    output logic                        reg_wr_out,
    output logic                        reg_rd_out,
    input  wire logic [SHBP_BUS_W-1:0]  reg_rdata_in,
    // Status
    output logic                        device_held_out,
    output logic                        frame_start_out,
    output logic      [SHBP_FCNT_W-1:0] frame_count_out
);
    typedef struct packed {
        logic                  sel;
        logic                  rd_act;
        logic                  wr_act;
        logic [SHBP_BUS_W-1:0] addr;
        logic [SHBP_BUS_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
        logic [SHBP_BUS_W-1:0] bus_out;
        logic                  bus_oe;
        logic                  held;
    } shbp_state_t;

    localparam shbp_state_t S_RESET = '{
        sel: 1'b0, rd_act: 1'b0, wr_act: 1'b0,
        addr: SHBP_ADDR_RST, wdata: SHBP_DATA_RST,
        wr: 1'b0, rd: 1'b0,
        bus_out: SHBP_DATA_RST, bus_oe: 1'b0, held: 1'b0
    };

    shbp_state_t s_q;
    shbp_state_t s_d;
    logic        sel;
    logic        strobe_style;
    logic        rd_act;
    logic        wr_act;

    shbp_frame_if frm ();

    // Decode the current access from the pins of the chosen style
    always_comb
    begin
        sel          = !chip_sel_n_in;
        strobe_style = (bus_style_in == SHBP_STYLE_DS_RW);
        if (strobe_style)
        begin
            // Direction line picks read or write while strobe is low
            rd_act = sel && !data_strobe_rd_n_in
                     && (dir_wr_n_in == SHBP_DIR_READ);
            wr_act = sel && !data_strobe_rd_n_in
                     && (dir_wr_n_in != SHBP_DIR_READ);
        end
        else
        begin
            rd_act = sel && !data_strobe_rd_n_in;
            wr_act = sel && !dir_wr_n_in;
        end
    end

    // Next state: address latch, write commit, read drive
    always_comb
    begin
        s_d        = s_q;
        s_d.sel    = sel;
        s_d.rd_act = rd_act;
        s_d.wr_act = wr_act;
        s_d.wr     = 1'b0;
        s_d.rd     = 1'b0;
        s_d.held   = 1'b0;
        // Multiplexed: address rides the bus as select goes low
        if (mux_mode_in == SHBP_MODE_MUX)
        begin
            if (sel && !s_q.sel)
                s_d.addr = bus_data_in;
        end
        else if ((rd_act && !s_q.rd_act) || (wr_act && !s_q.wr_act))
        begin
            s_d.addr = {{(SHBP_BUS_W-SHBP_SEL_W){1'b0}},
                        reg_select_msb_in, reg_select_lsb_in};
        end
        // Track data while the write strobe is held, so the value seen
        // just before release is committed
        if (wr_act)
            s_d.wdata = bus_data_in;
        // Write takes effect when the strobe is released
        if (s_q.wr_act && !wr_act)
            s_d.wr = 1'b1;
        if (rd_act && !s_q.rd_act)
            s_d.rd = 1'b1;
        // Drive only through a selected read; released otherwise
        s_d.bus_oe  = rd_act;
        s_d.bus_out = rd_act ? reg_rdata_in : SHBP_DATA_RST;
        // Device clear holds everything at its reset value and sets the held flag
        if (device_clear_in)
        begin
            s_d      = S_RESET;
            s_d.held = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            s_q <= S_RESET;
        else
            s_q <= s_d;
    end

    // Frame timing follows the sync pulse
    assign frm.sync  = frame_sync_pulse_in;
    assign frm.clear = device_clear_in;

    shbp_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_timer (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .frm      (frm)
    );

    // Outputs straight from flops
    assign bus_data_out    = s_q.bus_out;
    assign bus_oe_out      = s_q.bus_oe;
    assign reg_addr_out    = s_q.addr;
    assign reg_wdata_out   = s_q.wdata;
    assign reg_wr_out      = s_q.wr;
    assign reg_rd_out      = s_q.rd;
    assign device_held_out = s_q.held;
    assign frame_start_out = frm.start;
    assign frame_count_out = frm.count;

    property p_oe_rise;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        $rose(bus_oe_out) |-> $past(sel && !data_strobe_rd_n_in);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("bus driven without a selected read");

    property p_deselect;
        @(posedge clk_in) disable iff (reset_in)
        chip_sel_n_in |=> !bus_oe_out && !reg_rd_out;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("access seen while deselected");

    property p_clear;
        @(posedge clk_in) disable iff (reset_in)
        device_clear_in |=> device_held_out && !bus_oe_out && !reg_wr_out;
    endproperty
    a_clear: assert property (p_clear)
        else $error("device clear did not hold reset state");

    property p_dir_read;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        (strobe_style && sel && !data_strobe_rd_n_in && dir_wr_n_in)
            |=> bus_oe_out;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction high not decoded as read");

    property p_ds_end;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        // A clear in the cycle before wipes the active flag, so no commit
        (strobe_style && $past(wr_act) && !wr_act
            && !$past(device_clear_in)) |=> reg_wr_out;
    endproperty
    a_ds_end: assert property (p_ds_end)
        else $error("strobe release did not end the write");

    property p_wr_strobe;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        (!strobe_style && $past(sel && !dir_wr_n_in) && !wr_act
            && !$past(device_clear_in))
            |=> reg_wr_out ##1 !reg_wr_out;
    endproperty
    a_wr_strobe: assert property (p_wr_strobe)
        else $error("write strobe not recognised as one write");

    property p_rd_strobe;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        (!strobe_style && sel && !data_strobe_rd_n_in && !$past(rd_act))
            |=> reg_rd_out && bus_oe_out;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe)
        else $error("read strobe not recognised as read");

    property p_demux_addr;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        (reg_rd_out && !$past(mux_mode_in)) |->
            reg_addr_out == {6'h00, $past(reg_select_msb_in),
                             $past(reg_select_lsb_in)};
    endproperty
    a_demux_addr: assert property (p_demux_addr)
        else $error("register select not latched");

    property p_mux_addr;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        (mux_mode_in && sel && !$past(sel)) |=>
            reg_addr_out == $past(bus_data_in);
    endproperty
    a_mux_addr: assert property (p_mux_addr)
        else $error("multiplexed address not latched");

    property p_wdata;
        @(posedge clk_in) disable iff (reset_in || device_clear_in)
        (reg_wr_out && !$past(device_clear_in, 2))
            |-> reg_wdata_out == $past(bus_data_in, 2);
    endproperty
    a_wdata: assert property (p_wdata)
        else $error("write data not the last strobed value");
endmodule

// File: dv/shbp_host_model.sv
`timescale 1ns/1ps
// Host side of the shared data lines
module shbp_host_model
    import shbp_pkg::*;
(
    // Clock
    input  wire logic                  clk_in,
    // Host drive
    input  wire logic                  host_en_in,
    input  wire logic [SHBP_BUS_W-1:0] host_d_in,
    // Device drive
    input  wire logic                  dev_oe_in,
    input  wire logic [SHBP_BUS_W-1:0] dev_d_in,
    // Resolved wire
    output logic      [SHBP_BUS_W-1:0] wire_out
);
    logic [SHBP_BUS_W-1:0] last_q;
    // A floating bus toggles, so stale data never looks like a good read
    always_comb
    begin
        if (dev_oe_in)
            wire_out = dev_d_in;
        else if (host_en_in)
            wire_out = host_d_in;
        else
            wire_out = ~last_q;
    end
    // Last level, kept so that it can be inverted
    always_ff @(posedge clk_in)
        last_q <= wire_out;
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import shbp_pkg::*;
    localparam int FC = 16;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic style = 1'b1, mux = 1'b1, clr = 1'b0, cs_n = 1'b1, sync = 1'b0;
    logic dir_wr_n = 1'b1, ds_rd_n = 1'b1, sel_l = 1'b0, sel_m = 1'b0;
    logic host_en = 1'b0;
    logic [7:0] host_d = 8'h00, rdata = 8'h00;
    logic [7:0] bus_w, bus_o, addr_o, wd_o;
    logic oe, wr, rd, held, fstart;
    logic [SHBP_FCNT_W-1:0] fcnt;
    logic [16:0] exp_q [$];
    int bad_count = 0, total_checks = 0;

    // Shortened frame keeps the wrap check quick
    shbp_host_port #(.FRAME_CYCLES(FC)) uut (
        .clk_in(clk_in), .reset_in(reset_in), .bus_style_in(style),
        .mux_mode_in(mux), .device_clear_in(clr), .chip_sel_n_in(cs_n),
        .dir_wr_n_in(dir_wr_n), .data_strobe_rd_n_in(ds_rd_n),
        .reg_select_lsb_in(sel_l), .reg_select_msb_in(sel_m),
        .bus_data_in(bus_w), .bus_data_out(bus_o), .bus_oe_out(oe),
        .frame_sync_pulse_in(sync), .reg_addr_out(addr_o),
        .reg_wdata_out(wd_o), .reg_wr_out(wr), .reg_rd_out(rd),
        .reg_rdata_in(rdata), .device_held_out(held),
        .frame_start_out(fstart), .frame_count_out(fcnt));

    shbp_host_model host (
        .clk_in(clk_in), .host_en_in(host_en), .host_d_in(host_d),
        .dev_oe_in(oe), .dev_d_in(bus_o), .wire_out(bus_w));

    // Clock
    initial
        forever #2.5 clk_in = ~clk_in;

    task automatic check(input string what, input logic [16:0] seen,
                         input logic [16:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One selected access; address first, strobe one cycle later
    task automatic access(input logic r, input logic [7:0] a, d);
        logic [7:0] ea;
        // Mode strap was set by non-blocking assignment; read it one edge on
        @(posedge clk_in);
        ea = mux ? a : {6'h00, a[1:0]};
        exp_q.push_back({r, ea, d});
        cs_n <= 1'b0;
        host_en <= !(r && !mux);
        host_d <= mux ? a : d;
        {sel_m, sel_l} <= a[1:0];
        rdata <= d;
        @(posedge clk_in);
        if (mux)
        begin
            host_d <= d;
            host_en <= !r;
        end
        if (style)
        begin
            ds_rd_n <= 1'b0;
            dir_wr_n <= r;
        end
        else if (r)
            ds_rd_n <= 1'b0;
        else
            dir_wr_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        ds_rd_n <= 1'b1;
        dir_wr_n <= style ? dir_wr_n : 1'b1;
        @(posedge clk_in);
        cs_n <= 1'b1;
        host_en <= 1'b0;
        dir_wr_n <= 1'b1;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        check("bus released", oe, 1'b0);
    endtask

    // Each transfer pulse takes the oldest expectation
    always @(negedge clk_in)
        if (wr || rd)
        begin
            if (exp_q.size() == 0)
                check("unexpected transfer", 1'b1, 1'b0);
            else if (wr)
                check("write", {1'b0, addr_o, wd_o},
                      exp_q.pop_front());
            else
                check("read", {oe, addr_o, bus_o},
                      exp_q.pop_front());
        end

    // Main sequence
    initial
    begin
        void'($urandom(32'h7fac));
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        @(negedge clk_in);
        check("idle", {oe, wr, rd, held, fstart}, 5'h00);
        // Every style, mode and direction
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk_in);
            style <= k[2];
            mux <= k[1];
            access(k[0], 8'($urandom), 8'($urandom));
        end
        // Strobes while not selected must do nothing
        @(posedge clk_in);
        ds_rd_n <= 1'b0;
        dir_wr_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        ds_rd_n <= 1'b1;
        dir_wr_n <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("pending", 17'(exp_q.size()), 17'h00000);
        sync <= 1'b1;
        @(posedge clk_in);
        sync <= 1'b0;
        @(negedge clk_in);
        check("frame align", {fstart, fcnt}, 17'h10000);
        repeat (FC) @(posedge clk_in);
        @(negedge clk_in);
        check("frame wrap", {fstart, fcnt}, 17'h10000);
        @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        @(negedge clk_in);
        check("held", {held, fcnt}, 17'h10000);
        end_of_test();
    end

    // Watchdog, far beyond the hundred or so cycles the run needs
    initial
    begin
        #5000;
        bad_count++;
        end_of_test();
    end
endmodule
